// ---- pmc_pkg.sv ----
// pmc_pkg: types and constants for the privilege and mode controller.
// assumes a single clock domain; the core pipeline supplies all request pulses.
package pmc_pkg;

    // ----------------------------------------
    // operating states
    // ----------------------------------------
    typedef enum logic [1:0] {
        PMC_PRIV_THREAD   = 2'h0,
        PMC_USER_THREAD   = 2'h1,
        PMC_PRIV_HANDLER  = 2'h2
    } pmc_state_e;

    // ----------------------------------------
    // control word layout
    // ----------------------------------------
    localparam int          PMC_CTRL_W        = 2;
    localparam int          PMC_CTRL_USER_BIT = 0;
    localparam int          PMC_CTRL_ALT_BIT  = 1;
    localparam logic [1:0]  PMC_CTRL_RESET    = 2'h0;

    // ----------------------------------------
    // exception nesting and pad synchroniser
    // ----------------------------------------
    localparam logic [7:0]  PMC_NEST_IDLE     = 8'h00;
    localparam logic [7:0]  PMC_NEST_STEP     = 8'h01;
    localparam logic [7:0]  PMC_NEST_MAX      = 8'hFF;
    localparam logic [2:0]  PMC_SYNC_IDLE     = 3'h7;

    // ----------------------------------------
    // access classes the core may request
    // ----------------------------------------
    localparam int          PMC_ACC_W         = 2;
    localparam logic [1:0]  PMC_ACC_INSTR     = 2'h0;
    localparam logic [1:0]  PMC_ACC_SPECIAL   = 2'h1;
    localparam logic [1:0]  PMC_ACC_CONFIG    = 2'h2;
    localparam logic [1:0]  PMC_ACC_DEBUG     = 2'h3;

    // ----------------------------------------
    // fixed capabilities and address map
    // ----------------------------------------
    localparam int          PMC_ADDR_W        = 32;
    localparam logic [2:0]  PMC_RGN_CODE      = 3'h0;
    localparam logic [2:0]  PMC_RGN_SRAM      = 3'h1;
    localparam logic [2:0]  PMC_RGN_PERIPH    = 3'h2;
    localparam logic [2:0]  PMC_RGN_OTHER     = 3'h7;
    localparam logic [31:0] PMC_SRAM_BASE     = 32'h2000_0000;
    localparam logic [31:0] PMC_SRAM_BB_BASE  = 32'h2200_0000;
    localparam logic [31:0] PMC_SRAM_BB_END   = 32'h2400_0000;
    localparam logic [31:0] PMC_PERIPH_BASE   = 32'h4000_0000;
    localparam logic [31:0] PMC_PERIPH_END    = 32'h6000_0000;
    localparam int          PMC_BB_BIT_LSB    = 2;
    localparam int          PMC_BB_BIT_W      = 3;
    localparam int          PMC_BB_BYTE_LSB   = 5;
    localparam int          PMC_BB_BYTE_W     = 20;
    localparam int          PMC_NARROW_INSTR  = 16;
    localparam int          PMC_WIDE_INSTR    = 32;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic                 valid;
        logic                 priv;
        logic [PMC_ACC_W-1:0] kind;
    } pmc_access_s;

    typedef struct packed {
        logic                  valid;
        logic [PMC_ADDR_W-1:0] addr;
    } pmc_addr_s;

    typedef struct packed {
        logic        isBitBand;
        logic [31:0] wordAddr;
        logic [2:0]  bitIndex;
        logic [2:0]  region;
    } pmc_decode_s;

endpackage

// ---- pmc_addr_decode.sv ----
// pmc_addr_decode: maps a data address to its region and bit-band alias.
// assumes a combinational use inside the controller, same clock as the core.
`timescale 1ns/1ps
`default_nettype none
module pmc_addr_decode (
    input  wire logic [31:0]         addr,
    output var  pmc_pkg::pmc_decode_s dec
);
    import pmc_pkg::*;

    // ----------------------------------------
    // region and alias decode
    // ----------------------------------------
    always_comb begin
        dec           = '0;
        dec.region    = PMC_RGN_OTHER;
        if (addr < PMC_SRAM_BASE) begin
            dec.region = PMC_RGN_CODE;
        end else if (addr < PMC_PERIPH_BASE) begin
            dec.region = PMC_RGN_SRAM;
        end else if (addr < PMC_PERIPH_END) begin
            dec.region = PMC_RGN_PERIPH;
        end
        // each alias word stands for one bit of one SRAM byte
        if (addr >= PMC_SRAM_BB_BASE && addr < PMC_SRAM_BB_END) begin
            dec.isBitBand = 1'b1;
            dec.bitIndex  = addr[PMC_BB_BIT_LSB +: PMC_BB_BIT_W];
            dec.wordAddr  = PMC_SRAM_BASE
                          | {12'h000, addr[PMC_BB_BYTE_LSB +: PMC_BB_BYTE_W]};
        end
    end
endmodule
`default_nettype wire

// ---- pmc_mode_ctrl.sv ----
// pmc_mode_ctrl: privilege level, thread/handler mode and stack selection.
// assumes the core pulses exception entry/return and control writes on clk;
// extResetN comes straight from the pad and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                extResetN,
    input  wire logic                excEnter,
    input  wire logic                excReturn,
    input  wire logic                ctrlWrite,
    input  wire logic [1:0]          ctrlWdata,
    input  wire pmc_pkg::pmc_access_s accReq,
    input  wire pmc_pkg::pmc_addr_s   dataReq,
    input  wire logic                instrWide,
    input  wire logic                instrLegacy,
    output var  pmc_pkg::pmc_state_e  state,
    output logic                     privileged,
    output logic                     handlerMode,
    output logic [1:0]               ctrlRead,
    output logic                     useProcessSp,
    output logic                     accGrant,
    output logic                     faultPulse,
    output var  pmc_pkg::pmc_decode_s dataDec,
    output logic                     unalignedOk,
    output logic [5:0]               instrBits,
    output logic                     coreResetReq
);
    import pmc_pkg::*;

    // ----------------------------------------
    // external reset pin synchroniser
    // ----------------------------------------
    // pad is pulled up in the pad ring, so an open pin reads high (inactive)
    logic [2:0] xresSync_ff;
    logic       xresLow_ff;
    logic       xresStage2;
    logic       xresStage3;
    logic       xresSettled;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xresSync_ff <= PMC_SYNC_IDLE;
        end else begin
            xresSync_ff <= {xresSync_ff[1:0], extResetN};
        end
    end

    // only stages two and three are looked at; stage one may still be metastable
    assign xresStage2  = xresSync_ff[1];
    assign xresStage3  = xresSync_ff[2];
    assign xresSettled = (xresStage2 == xresStage3);

    // a change counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xresLow_ff <= 1'b0;
        end else if (xresSettled) begin
            xresLow_ff <= ~xresStage3;
        end
    end

    // ----------------------------------------
    // control word and nesting depth
    // ----------------------------------------
    logic [1:0] ctrl_ff;
    logic [1:0] nxt_ctrl;
    logic [7:0] nest_ff;
    logic [7:0] nxt_nest;
    logic       inHandler;
    logic       ctrlAllowed;
    logic       nestFull;
    logic       nestUp;
    logic       nestDown;

    assign inHandler   = (nest_ff != PMC_NEST_IDLE);
    // user code cannot raise itself back to privileged
    assign ctrlAllowed = ctrlWrite && (inHandler || !ctrl_ff[PMC_CTRL_USER_BIT]);

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (ctrlAllowed) begin
            nxt_ctrl[PMC_CTRL_USER_BIT] = ctrlWdata[PMC_CTRL_USER_BIT];
            nxt_ctrl[PMC_CTRL_ALT_BIT]  = ctrlWdata[PMC_CTRL_ALT_BIT];
        end
        // handler has no alternate stack; ignore attempts to set it
        if (inHandler && ctrlAllowed) begin
            nxt_ctrl[PMC_CTRL_ALT_BIT] = ctrl_ff[PMC_CTRL_ALT_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= PMC_CTRL_RESET;
        end else if (xresLow_ff) begin
            // pad reset beats any control write pending in the same cycle
            ctrl_ff <= PMC_CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // entry and return in one cycle cancel; depth saturates rather than wrapping to thread
    assign nestFull = (nest_ff == PMC_NEST_MAX);
    assign nestUp   = excEnter && !excReturn && !nestFull;
    assign nestDown = excReturn && !excEnter && inHandler;

    always_comb begin
        nxt_nest = nest_ff;
        if (nestUp) begin
            nxt_nest = nest_ff + PMC_NEST_STEP;
        end else if (nestDown) begin
            nxt_nest = nest_ff - PMC_NEST_STEP;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nest_ff <= PMC_NEST_IDLE;
        end else if (xresLow_ff) begin
            nest_ff <= PMC_NEST_IDLE;
        end else begin
            nest_ff <= nxt_nest;
        end
    end

    // ----------------------------------------
    // state view
    // ----------------------------------------
    always_comb begin
        if (inHandler) begin
            state = PMC_PRIV_HANDLER;
        end else if (ctrl_ff[PMC_CTRL_USER_BIT]) begin
            state = PMC_USER_THREAD;
        end else begin
            state = PMC_PRIV_THREAD;
        end
    end

    assign privileged   = (state != PMC_USER_THREAD);
    assign handlerMode  = inHandler;
    // bit 1 reads as zero while handling
    assign ctrlRead     = {ctrl_ff[PMC_CTRL_ALT_BIT] & ~inHandler,
                           ctrl_ff[PMC_CTRL_USER_BIT]};
    // process stack strictly in user thread mode
    assign useProcessSp = (state == PMC_USER_THREAD);
    // held for the whole settled low pulse of the pad
    assign coreResetReq = xresLow_ff;

    // ----------------------------------------
    // access gating and fault
    // ----------------------------------------
    logic grant_ff;
    logic fault_ff;
    logic legacyFault;
    logic userProtected;
    logic accAllowed;

    assign legacyFault = instrLegacy;

    // only a protected class is held back below the privileged level
    assign userProtected = accReq.valid && !privileged && accReq.priv;
    assign accAllowed    = accReq.valid && (privileged || !accReq.priv);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            grant_ff <= 1'b0;
        end else begin
            grant_ff <= accAllowed;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= userProtected || legacyFault;
        end
    end

    assign accGrant   = grant_ff;
    assign faultPulse = fault_ff;

    // ----------------------------------------
    // data address decode and capabilities
    // ----------------------------------------
    pmc_decode_s decNow;
    pmc_decode_s dec_ff;
    logic [5:0]  ibits_ff;
    logic [5:0]  ibitsNow;

    pmc_addr_decode uDecode (
        .addr (dataReq.addr),
        .dec  (decNow)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dec_ff <= '0;
        end else if (dataReq.valid) begin
            dec_ff <= decNow;
        end
    end

    assign ibitsNow = instrWide ? 6'(PMC_WIDE_INSTR) : 6'(PMC_NARROW_INSTR);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ibits_ff <= 6'(PMC_NARROW_INSTR);
        end else begin
            ibits_ff <= ibitsNow;
        end
    end

    // decode holds between requests, so the core may pick it up late
    assign dataDec     = dec_ff;
    // the core splits misaligned words itself, so nothing here is refused
    assign unalignedOk = 1'b1;
    assign instrBits   = ibits_ff;
endmodule
`default_nettype wire

// ---- pmc_sva.sv ----
// pmc_sva: port checks for the privilege and mode controller
// assumes a bind onto pmc_mode_ctrl; one clock, async active-high rst
`timescale 1ns/1ps
`default_nettype none
module pmc_sva
    import pmc_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 excEnter,
    input wire logic                 excReturn,
    input wire logic                 ctrlWrite,
    input wire logic [1:0]           ctrlWdata,
    input wire pmc_pkg::pmc_access_s accReq,
    input wire logic                 instrWide,
    input wire logic                 instrLegacy,
    input wire pmc_pkg::pmc_state_e  state,
    input wire logic                 privileged,
    input wire logic                 handlerMode,
    input wire logic [1:0]           ctrlRead,
    input wire logic                 useProcessSp,
    input wire logic                 accGrant,
    input wire logic                 faultPulse,
    input wire logic                 unalignedOk,
    input wire logic [5:0]           instrBits
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // request shapes
    // ----
    sequence s_user_prot;
        accReq.valid && accReq.priv && !privileged;
    endsequence
    sequence s_priv_req;
        accReq.valid && privileged && !instrLegacy;
    endsequence
    sequence s_go_user;
        ctrlWrite && ctrlWdata[0] && state == PMC_PRIV_THREAD && !excEnter;
    endsequence
    // ----
    // checks
    // ----
    a_three_states: assert property (
        privileged == (state != PMC_USER_THREAD) && state != 2'h3) else $error("bad state");
    a_user_fault: assert property (s_user_prot |=> faultPulse && !accGrant)
        else $error("user access not faulted");
    a_priv_grant: assert property (s_priv_req |=> accGrant && !faultPulse)
        else $error("privileged access refused");
    a_exc_enter: assert property (
        excEnter && !excReturn |=> handlerMode && state == PMC_PRIV_HANDLER)
        else $error("no handler mode on entry");
    a_handler_main: assert property (
        handlerMode |-> privileged && !useProcessSp && !ctrlRead[1])
        else $error("handler off main stack");
    a_go_user: assert property (s_go_user |=> useProcessSp && !privileged)
        else $error("user bit ignored");
    a_user_drop: assert property (
        ctrlWrite && !excEnter && state == PMC_USER_THREAD |=> $stable(state))
        else $error("user write took effect");
    a_psp_user: assert property (useProcessSp == (state == PMC_USER_THREAD))
        else $error("stack select wrong");
    a_wide_bits: assert property (instrWide |=> instrBits == 6'h20)
        else $error("wide width wrong");
    a_legacy_fault: assert property (instrLegacy |=> faultPulse)
        else $error("legacy not faulted");
    a_unaligned_ok: assert property (unalignedOk) else $error("unaligned off");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// tb_top: directed bench for the privilege and mode controller
// assumes pmc_pkg, pmc_mode_ctrl and pmc_sva are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        extResetN = 1'b1;
    logic        excEnter = 1'b0;
    logic        excReturn = 1'b0;
    logic        ctrlWrite = 1'b0;
    logic [1:0]  ctrlWdata = 2'h0;
    pmc_access_s accReq = '0;
    pmc_addr_s   dataReq = '0;
    logic        instrWide = 1'b0;
    logic        instrLegacy = 1'b0;
    pmc_state_e  state;
    pmc_decode_s dataDec;
    logic        privileged, handlerMode, useProcessSp, accGrant, faultPulse;
    logic        unalignedOk, coreResetReq;
    logic [1:0]  ctrlRead;
    logic [5:0]  instrBits;
    int          err_count = 0;
    int          samples_checked = 0;

    always #4 clk = ~clk;

    pmc_mode_ctrl dut_u (
        .clk(clk), .rst(rst), .extResetN(extResetN), .excEnter(excEnter),
        .excReturn(excReturn), .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata),
        .accReq(accReq), .dataReq(dataReq), .instrWide(instrWide),
        .instrLegacy(instrLegacy), .state(state), .privileged(privileged),
        .handlerMode(handlerMode), .ctrlRead(ctrlRead), .useProcessSp(useProcessSp),
        .accGrant(accGrant), .faultPulse(faultPulse), .dataDec(dataDec),
        .unalignedOk(unalignedOk), .instrBits(instrBits), .coreResetReq(coreResetReq)
    );

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one-cycle pulses; an idle edge first, so back-to-back calls never re-raise in one step
    task automatic ev(input logic e, input logic r, input logic w, input logic [1:0] d);
        @(negedge clk);
        excEnter = e;
        excReturn = r;
        ctrlWrite = w;
        ctrlWdata = d;
        @(negedge clk);
        {excEnter, excReturn, ctrlWrite} = 3'h0;
    endtask

    task automatic acc(input logic pv, input logic [1:0] k, input logic ok);
        @(negedge clk);
        accReq = '{1'b1, pv, k};
        @(negedge clk);
        accReq = '0;
        chk("accGrant", ok, accGrant);
        chk("faultPulse", !ok, faultPulse);
    endtask

    task automatic dec(input logic [31:0] a, input logic bb, input logic [2:0] rg);
        @(negedge clk);
        dataReq = '{1'b1, a};
        @(negedge clk);
        dataReq = '0;
        chk("isBitBand", bb, dataDec.isBitBand);
        chk("region", rg, dataDec.region);
    endtask

    task automatic t_reset;
        chk("state", PMC_PRIV_THREAD, state);
        chk("useProcessSp", 1'b0, useProcessSp);
        chk("instrBits", 6'h10, instrBits);
    endtask

    task automatic t_levels;
        for (int k = 0; k < 4; k++) acc(1'b1, k[1:0], 1'b1);
        ev(1'b0, 1'b0, 1'b1, 2'h1);
        chk("state", PMC_USER_THREAD, state);
        chk("useProcessSp", 1'b1, useProcessSp);
        for (int k = 0; k < 4; k++) acc(1'b1, k[1:0], 1'b0);
        acc(1'b0, PMC_ACC_INSTR, 1'b1);
        ev(1'b0, 1'b0, 1'b1, 2'h0);
        chk("state", PMC_USER_THREAD, state);
    endtask

    // nested entry; bit1 write inside the handler must not stick
    task automatic t_exc;
        ev(1'b1, 1'b0, 1'b0, 2'h0);
        chk("state", PMC_PRIV_HANDLER, state);
        chk("useProcessSp", 1'b0, useProcessSp);
        ev(1'b1, 1'b0, 1'b1, 2'h3);
        chk("ctrlRead1", 1'b0, ctrlRead[1]);
        acc(1'b1, PMC_ACC_DEBUG, 1'b1);
        ev(1'b0, 1'b1, 1'b0, 2'h0);
        chk("handlerMode", 1'b1, handlerMode);
        ev(1'b0, 1'b1, 1'b0, 2'h0);
        chk("state", PMC_USER_THREAD, state);
        chk("ctrlRead", 2'h1, ctrlRead);
    endtask

    task automatic t_misc;
        dec(32'h2200_043C, 1'b1, PMC_RGN_SRAM);
        chk("bitIndex", 3'h7, dataDec.bitIndex);
        chk("wordAddr", 32'h2000_0021, dataDec.wordAddr);
        dec(32'h2000_0010, 1'b0, PMC_RGN_SRAM);
        dec(32'h4000_0000, 1'b0, PMC_RGN_PERIPH);
        dec(32'h0000_1000, 1'b0, PMC_RGN_CODE);
        dec(32'h6000_0000, 1'b0, PMC_RGN_OTHER);
        instrWide = 1'b1;
        @(negedge clk);
        instrWide = 1'b0;
        chk("instrBits", 6'h20, instrBits);
        instrLegacy = 1'b1;
        @(negedge clk);
        instrLegacy = 1'b0;
        chk("faultPulse", 1'b1, faultPulse);
        chk("unalignedOk", 1'b1, unalignedOk);
    endtask

    // pad reset from user thread: must fall back to privileged thread
    task automatic t_ext;
        extResetN = 1'b0;
        repeat (6) @(negedge clk);
        chk("coreResetReq", 1'b1, coreResetReq);
        chk("state", PMC_PRIV_THREAD, state);
        extResetN = 1'b1;
        repeat (6) @(negedge clk);
        chk("coreResetReq", 1'b0, coreResetReq);
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_levels();
        t_exc();
        t_misc();
        t_ext();
        close_out();
    end

    // whole run is about 68 cycles; this leaves a wide margin
    initial begin
        #20000;
        err_count++;
        close_out();
    end
endmodule

bind pmc_mode_ctrl pmc_sva chk_u (
    .clk(clk), .rst(rst), .excEnter(excEnter), .excReturn(excReturn),
    .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata), .accReq(accReq),
    .instrWide(instrWide), .instrLegacy(instrLegacy), .state(state),
    .privileged(privileged), .handlerMode(handlerMode), .ctrlRead(ctrlRead),
    .useProcessSp(useProcessSp), .accGrant(accGrant), .faultPulse(faultPulse),
    .unalignedOk(unalignedOk), .instrBits(instrBits)
);
`default_nettype wire
